/* File: design/charge_port_defines.svh */
/*
 * Timing constants and widths for the charge port mode controller.
 * Assumes a single 25 MHz system clock; all times are in microseconds.
 */
`ifndef CHARGE_PORT_DEFINES_SVH
`define CHARGE_PORT_DEFINES_SVH

// system clock rate
`define CLK_FREQ_MHZ 25
// width of the interval timers
`define TIMER_W 24
// output discharge interval
`define DISCHARGE_TIME_US 10000
// length of the 1.2 V signature before the shorted scheme
`define V1P2_TIME_US 100000
// settle time of the reversed divider trial before the current is checked
`define TRIAL_TIME_US 50000
// cycle counts derived from the times above
`define DISCHARGE_CYCLES (`DISCHARGE_TIME_US * `CLK_FREQ_MHZ)
`define V1P2_CYCLES (`V1P2_TIME_US * `CLK_FREQ_MHZ)
`define TRIAL_CYCLES (`TRIAL_TIME_US * `CLK_FREQ_MHZ)
// number of asynchronous input bits that are synchronised
`define SYNC_W 11

`endif

/* File: design/charge_port_pkg.sv */
/*
 * Types shared by the charge port mode controller and its bench.
 * Assumes nothing beyond the defines header.
 */
`default_nettype none

package charge_port_pkg;

    // mode pins as they arrive from the host system
    typedef struct packed {
        logic mode_select_a;
        logic mode_select_b;
        logic mode_select_c;
        logic current_limit_choice;
    } pins_t;

    // single-bit flags from the analog sensing circuitry
    typedef struct packed {
        logic over_temp;
        logic in_current_limit;
        logic above_750ma;
        logic bc_attach;
        logic line_held;
    } sense_t;

    // decoded charging mode
    typedef enum logic [2:0] {
        MODE_DISCHARGE = 3'h0,
        MODE_AUTO = 3'h1,
        MODE_SDP1 = 3'h2,
        MODE_FORCED_SHORT = 3'h3,
        MODE_FORCED_DIV1 = 3'h4,
        MODE_SDP2 = 3'h5,
        MODE_CDP = 3'h6
    } mode_t;

    // signature presented on D+/D-
    typedef enum logic [2:0] {
        SIG_NONE = 3'h0,
        SIG_FIRST_DIVIDER = 3'h1,
        SIG_SECOND_DIVIDER = 3'h2,
        SIG_V1P2 = 3'h3,
        SIG_SHORTED = 3'h4
    } sig_t;

    // charging state machine
    typedef enum logic [2:0] {
        TOP_INIT = 3'h1,
        TOP_DISCHARGE = 3'h2,
        TOP_RUN = 3'h4
    } top_state_t;

    // dedicated charge autodetect state machine
    typedef enum logic [5:0] {
        AD_FIRST_DIV = 6'h01,
        AD_TRIAL = 6'h02,
        AD_SECOND_DIV = 6'h04,
        AD_DISCHARGE = 6'h08,
        AD_V1P2 = 6'h10,
        AD_SHORTED = 6'h20
    } ad_state_t;

endpackage : charge_port_pkg

`default_nettype wire

/* File: design/interval_timer.sv */
/*
 * Down-counting interval timer: a start pulse loads a cycle count,
 * busy stays high while it runs and done pulses for one cycle at the end.
 * Assumes start is a one-cycle pulse on the same clock.
 */
`default_nettype none
`include "charge_port_defines.svh"

module interval_timer (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // control
    input wire logic start_in,
    input wire logic [`TIMER_W-1:0] load_in,
    // status
    output logic busy_out,
    output logic done_out
);

    logic [`TIMER_W-1:0] cnt_r;
    logic [`TIMER_W-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        // a restart while running reloads, so the interval is always whole
        if (start_in) begin
            cnt_nxt = load_in;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - `TIMER_W'(1);
            done_nxt = (cnt_r == `TIMER_W'(1));
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = (cnt_r != '0);
    assign done_out = done_r;

endmodule : interval_timer

`default_nettype wire

/* File: design/pin_sync.sv */
/*
 * Two-flop synchroniser for a bus of independent level inputs.
 * Assumes each bit is a slow level; no bit-to-bit coherence is given.
 */
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule : pin_sync

`default_nettype wire

/* File: design/usb_charge_port_mode_control.sv */
/*
 * Mode control of a USB charging port: mode decode, data switch gating,
 * output discharge sequencing and the dedicated charge autodetect machine.
 * Assumes mode pins, enable, power-on reset and sense flags come from
 * outside the clock domain; analog levels are made from signature_out.
 */
// What this block does
// - close data switches in standard/charging downstream modes
// - open switches: enable low, pins 000, dedicated
// - current limit alone never opens data switches
// - switches open while output discharges
// - switches stay closed during charging port handshake
// - power-on reset: initial state, output discharging
// - power-on reset always returns to initial state
// - after power-on reset, go to selected mode
// - renegotiate: switch off, discharge, switch on
// - autodetect starts with first divider signature
// - compliant attach: discharge, 1.2 V, then shorted
// - shorted until line released, then first divider
// - divider responder keeps first divider state
// - above 750 mA on first divider: try second
// - keep second divider only if current stays high
// - second divider swaps the first divider levels
// - 1.2 V shorted signature for fixed interval
// - shorted scheme joins D+ and D- low-impedance
// - forced mode holds one scheme, no detection
// - enable low opens all switches, discharges output
// - decode pins into mode and current limit
// - 1111 to 1110 swap causes no discharge
// - active-low fault on over-temperature or limit
`default_nettype none
`include "charge_port_defines.svh"

module usb_charge_port_mode_control #(
    parameter logic [`TIMER_W-1:0] DISCHARGE_CYCLES = `TIMER_W'(`DISCHARGE_CYCLES),
    parameter logic [`TIMER_W-1:0] V1P2_CYCLES = `TIMER_W'(`V1P2_CYCLES),
    parameter logic [`TIMER_W-1:0] TRIAL_CYCLES = `TIMER_W'(`TRIAL_CYCLES)
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // host controls
    input wire charge_port_pkg::pins_t pins_in,
    input wire logic enable_in,
    input wire logic por_in,
    // analog sense flags
    input wire charge_port_pkg::sense_t sense_in,
    // switch controls
    output logic data_switch_on_out,
    output logic power_switch_on_out,
    output logic discharge_out,
    output logic high_limit_out,
    // data line signature and status
    output charge_port_pkg::sig_t signature_out,
    output charge_port_pkg::mode_t mode_out,
    output logic fault_n_out
);

    import charge_port_pkg::*;

    // decodes the pin pattern into a charging mode
    function automatic mode_t decode_mode(input pins_t p);
        mode_t m;
        m = MODE_DISCHARGE;
        unique case ({p.mode_select_a, p.mode_select_b, p.mode_select_c})
            3'h0: m = MODE_DISCHARGE;
            3'h1, 3'h3: m = MODE_AUTO;
            3'h2, 3'h6: m = MODE_SDP1;
            3'h4: m = MODE_FORCED_SHORT;
            3'h5: m = MODE_FORCED_DIV1;
            3'h7: m = p.current_limit_choice ? MODE_CDP : MODE_SDP2;
        endcase
        return m;
    endfunction : decode_mode

    // high limit: autodetect always high, otherwise the choice pin
    function automatic logic decode_limit(input pins_t p);
        logic auto_sel;
        auto_sel = !p.mode_select_a && p.mode_select_c;
        return auto_sel || p.current_limit_choice;
    endfunction : decode_limit

    // modes that pass data through the switch
    function automatic logic is_data_mode(input mode_t m);
        return (m == MODE_SDP1) || (m == MODE_SDP2) || (m == MODE_CDP);
    endfunction : is_data_mode

    // synchronised inputs
    logic [`SYNC_W-1:0] sync_s;
    pins_t pins_s;
    sense_t sense_s;
    logic enable_s;
    logic por_s;

    pin_sync #(
        .WIDTH(`SYNC_W)
    ) u_sync (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in({pins_in, enable_in, por_in, sense_in}),
        .sync_out(sync_s)
    );

    assign {pins_s, enable_s, por_s, sense_s} = sync_s;

    // interval timers
    logic disch_start;
    logic disch_done;
    logic v12_start;
    logic v12_done;
    logic trial_start;
    logic trial_done;

    interval_timer u_disch_timer (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .start_in(disch_start),
        .load_in(DISCHARGE_CYCLES),
        .busy_out(),
        .done_out(disch_done)
    );

    interval_timer u_v12_timer (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .start_in(v12_start),
        .load_in(V1P2_CYCLES),
        .busy_out(),
        .done_out(v12_done)
    );

    interval_timer u_trial_timer (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .start_in(trial_start),
        .load_in(TRIAL_CYCLES),
        .busy_out(),
        .done_out(trial_done)
    );

    // state
    top_state_t top_state_r;
    top_state_t top_state_nxt;
    ad_state_t ad_state_r;
    ad_state_t ad_state_nxt;
    mode_t mode_r;
    mode_t mode_nxt;
    mode_t mode_req;
    logic swap_ok;

    always_comb begin
        mode_req = decode_mode(pins_s);
        // sdp2 and cdp differ only in the limit choice, so no renegotiation
        swap_ok = ((mode_r == MODE_SDP2) && (mode_req == MODE_CDP)) ||
                  ((mode_r == MODE_CDP) && (mode_req == MODE_SDP2));
        top_state_nxt = top_state_r;
        ad_state_nxt = ad_state_r;
        mode_nxt = mode_r;
        disch_start = 1'b0;
        v12_start = 1'b0;
        trial_start = 1'b0;
        if (por_s) begin
            top_state_nxt = TOP_INIT;
            ad_state_nxt = AD_FIRST_DIV;
        end else begin
            unique case (top_state_r)
                TOP_INIT: begin
                    top_state_nxt = TOP_RUN;
                    mode_nxt = mode_req;
                    ad_state_nxt = AD_FIRST_DIV;
                end
                TOP_DISCHARGE: begin
                    mode_nxt = mode_req;
                    if (disch_done) begin
                        top_state_nxt = TOP_RUN;
                        ad_state_nxt = AD_FIRST_DIV;
                    end
                end
                TOP_RUN: begin
                    if (mode_req != mode_r) begin
                        mode_nxt = mode_req;
                        if (!swap_ok) begin
                            top_state_nxt = TOP_DISCHARGE;
                            disch_start = 1'b1;
                        end
                    end else if (mode_r == MODE_AUTO) begin
                        unique case (ad_state_r)
                            AD_FIRST_DIV: begin
                                // no attach and no high current: stay here
                                if (sense_s.bc_attach) begin
                                    ad_state_nxt = AD_DISCHARGE;
                                    disch_start = 1'b1;
                                end else if (sense_s.above_750ma) begin
                                    ad_state_nxt = AD_TRIAL;
                                    trial_start = 1'b1;
                                end
                            end
                            AD_TRIAL: begin
                                if (trial_done) begin
                                    ad_state_nxt = sense_s.above_750ma ?
                                        AD_SECOND_DIV : AD_FIRST_DIV;
                                end
                            end
                            AD_SECOND_DIV: ad_state_nxt = AD_SECOND_DIV;
                            AD_DISCHARGE: begin
                                if (disch_done) begin
                                    ad_state_nxt = AD_V1P2;
                                    v12_start = 1'b1;
                                end
                            end
                            AD_V1P2: begin
                                if (v12_done) begin
                                    ad_state_nxt = AD_SHORTED;
                                end
                            end
                            AD_SHORTED: begin
                                if (!sense_s.line_held) begin
                                    ad_state_nxt = AD_FIRST_DIV;
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            top_state_r <= TOP_INIT;
            ad_state_r <= AD_FIRST_DIV;
            mode_r <= MODE_DISCHARGE;
        end else begin
            top_state_r <= top_state_nxt;
            ad_state_r <= ad_state_nxt;
            mode_r <= mode_nxt;
        end
    end

    // outputs, computed from next state so they line up with it
    logic discharging_nxt;
    logic data_sw_nxt;
    logic high_limit_nxt;
    logic fault_n_nxt;
    sig_t sig_nxt;
    logic data_sw_r;
    logic power_on_r;
    logic discharge_r;
    logic high_limit_r;
    logic fault_n_r;
    sig_t sig_r;

    always_comb begin
        discharging_nxt = (top_state_nxt != TOP_RUN) || !enable_s ||
                          (mode_nxt == MODE_DISCHARGE) ||
                          ((mode_nxt == MODE_AUTO) &&
                           (ad_state_nxt == AD_DISCHARGE));
        // current limit is deliberately not a term here
        data_sw_nxt = enable_s && !discharging_nxt &&
                      is_data_mode(mode_nxt);
        high_limit_nxt = decode_limit(pins_s);
        fault_n_nxt = !(sense_s.over_temp || sense_s.in_current_limit);
        sig_nxt = SIG_NONE;
        if (!discharging_nxt) begin
            unique case (mode_nxt)
                MODE_FORCED_SHORT: sig_nxt = SIG_SHORTED;
                MODE_FORCED_DIV1: sig_nxt = SIG_FIRST_DIVIDER;
                MODE_AUTO: begin
                    unique case (ad_state_nxt)
                        AD_FIRST_DIV: sig_nxt = SIG_FIRST_DIVIDER;
                        AD_TRIAL, AD_SECOND_DIV: sig_nxt = SIG_SECOND_DIVIDER;
                        AD_DISCHARGE: sig_nxt = SIG_NONE;
                        AD_V1P2: sig_nxt = SIG_V1P2;
                        AD_SHORTED: sig_nxt = SIG_SHORTED;
                    endcase
                end
                default: sig_nxt = SIG_NONE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_sw_r <= 1'b0;
            power_on_r <= 1'b0;
            discharge_r <= 1'b1;
            high_limit_r <= 1'b0;
            fault_n_r <= 1'b1;
            sig_r <= SIG_NONE;
        end else begin
            data_sw_r <= data_sw_nxt;
            power_on_r <= !discharging_nxt;
            discharge_r <= discharging_nxt;
            high_limit_r <= high_limit_nxt;
            fault_n_r <= fault_n_nxt;
            sig_r <= sig_nxt;
        end
    end

    assign data_switch_on_out = data_sw_r;
    assign power_switch_on_out = power_on_r;
    assign discharge_out = discharge_r;
    assign high_limit_out = high_limit_r;
    assign signature_out = sig_r;
    assign mode_out = mode_r;
    assign fault_n_out = fault_n_r;

endmodule : usb_charge_port_mode_control

`default_nettype wire

/* File: testbench/portable_device_model.sv */
/*
 * Portable device on the port: a compliant device that holds the line
 * while attached, and a load that draws high current from a divider.
 * Assumes the bench commands attach and draw as levels.
 */
`default_nettype none

module portable_device_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // port side
    input wire charge_port_pkg::sig_t signature_in,
    input wire logic attach_in,
    input wire logic draw_high_in,
    // sensed by the port
    output logic above_750ma_out,
    output logic bc_attach_out,
    output logic line_held_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import charge_port_pkg::*;
    logic served_r;

    // once shorted, the device is satisfied and stops asking
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in)
            served_r <= 1'b0;
        else
            served_r <= attach_in && (served_r || signature_in == SIG_SHORTED);
    end
    assign bc_attach_out = attach_in && !served_r;
    assign line_held_out = attach_in;
    assign above_750ma_out = draw_high_in && (signature_in == SIG_FIRST_DIVIDER
        || signature_in == SIG_SECOND_DIVIDER);
endmodule : portable_device_model

`default_nettype wire

/* File: testbench/usb_charge_port_mode_control_checker.sv */
/*
 * Concurrent checks on the charge port mode controller ports.
 * Assumes one clock domain and the 3-edge input-to-output latency.
 */
`default_nettype none

module charge_port_checker (
    // clock and reset
    input wire logic clock_in,
    input wire logic resetn_in,
    // inputs
    input wire charge_port_pkg::pins_t pins_in,
    input wire logic enable_in,
    input wire logic por_in,
    input wire charge_port_pkg::sense_t sense_in,
    // outputs
    input wire logic data_switch_on_out,
    input wire logic power_switch_on_out,
    input wire logic discharge_out,
    input wire logic high_limit_out,
    input wire charge_port_pkg::sig_t signature_out,
    input wire charge_port_pkg::mode_t mode_out,
    input wire logic fault_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import charge_port_pkg::*;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    // autodetect shorted scheme, then a settled release of the line; forced short
    // mode never leaves its scheme, so the mode term keeps it out
    sequence released_s;
        signature_out == SIG_SHORTED && mode_out == MODE_AUTO ##0
            ($stable(pins_in) && enable_in && !por_in && !sense_in.line_held)[*4];
    endsequence
    sequence attach_s;
        signature_out == SIG_FIRST_DIVIDER && mode_out == MODE_AUTO ##0
            ($stable(pins_in) && enable_in && !por_in && sense_in.bc_attach
             && !sense_in.above_750ma)[*4];
    endsequence

    a_discharge_isolates: assert property (
        discharge_out |-> !power_switch_on_out && !data_switch_on_out)
        else $error("switch on in discharge");
    a_dedicated_data_off: assert property (
        mode_out inside {MODE_DISCHARGE, MODE_AUTO, MODE_FORCED_SHORT, MODE_FORCED_DIV1}
        |-> !data_switch_on_out)
        else $error("data switch on in dedicated mode");
    a_enable_low_off: assert property (
        (!enable_in)[*5] |-> discharge_out && !data_switch_on_out)
        else $error("enable low not honoured");
    a_por_holds_init: assert property (
        por_in[*5] |-> discharge_out && signature_out == SIG_NONE)
        else $error("por not holding init");
    a_data_on_port: assert property (
        (enable_in && !por_in)[*5] ##0 (mode_out inside
        {MODE_SDP1, MODE_SDP2, MODE_CDP} && !discharge_out) |-> data_switch_on_out)
        else $error("data switch open in port mode");
    a_fault_follows: assert property (
        $stable(sense_in)[*4] |-> fault_n_out ==
        !(sense_in.over_temp || sense_in.in_current_limit))
        else $error("fault wrong");
    a_swap_no_discharge: assert property (
        $past(mode_out) == MODE_CDP && mode_out == MODE_SDP2 |-> !discharge_out)
        else $error("discharge on limit swap");
    a_v1p2_to_short: assert property (
        $fell(signature_out == SIG_V1P2) && !discharge_out
        && mode_out == MODE_AUTO |-> signature_out == SIG_SHORTED)
        else $error("1.2V not followed by shorted");
    a_release_divider: assert property (
        released_s |-> signature_out == SIG_FIRST_DIVIDER)
        else $error("no return to first divider");
    a_attach_discharge: assert property (
        attach_s |-> discharge_out)
        else $error("no discharge on attach");
endmodule : charge_port_checker

bind usb_charge_port_mode_control charge_port_checker charge_port_checker_i (
    .clock_in(clock_in), .resetn_in(resetn_in), .pins_in(pins_in),
    .enable_in(enable_in), .por_in(por_in), .sense_in(sense_in),
    .data_switch_on_out(data_switch_on_out), .power_switch_on_out(power_switch_on_out),
    .discharge_out(discharge_out), .high_limit_out(high_limit_out),
    .signature_out(signature_out), .mode_out(mode_out), .fault_n_out(fault_n_out));

`default_nettype wire

/* File: testbench/usb_charge_port_mode_control_tb_top.sv */
/*
 * Self-checking bench: mode table sweep, enable, por and autodetect.
 * Assumes short interval parameters 8, 16 and 8 cycles.
 */
`default_nettype none

module usb_charge_port_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import charge_port_pkg::*;
    logic clock_in, resetn_in, enable_in, por_in, ot, icl, attach, draw;
    logic above, bc, held, data_on, power_on, disch, hl, fault_n;
    pins_t pins;
    sig_t sig;
    mode_t mode;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 66573;

    usb_charge_port_mode_control #(.DISCHARGE_CYCLES(24'h8), .V1P2_CYCLES(24'h10),
        .TRIAL_CYCLES(24'h8)) usb_charge_port_mode_control_i (
        .clock_in(clock_in), .resetn_in(resetn_in), .pins_in(pins),
        .enable_in(enable_in), .por_in(por_in), .sense_in({ot, icl, above, bc, held}),
        .data_switch_on_out(data_on), .power_switch_on_out(power_on),
        .discharge_out(disch), .high_limit_out(hl), .signature_out(sig),
        .mode_out(mode), .fault_n_out(fault_n));
    portable_device_model portable_device_model_i (.clock_in(clock_in),
        .resetn_in(resetn_in), .signature_in(sig), .attach_in(attach),
        .draw_high_in(draw), .above_750ma_out(above), .bc_attach_out(bc),
        .line_held_out(held));

    initial begin
        clock_in = 0;
        forever #20 clock_in = ~clock_in;
    end

    task results;
        if (n_mismatch == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            results;
        end
    end

    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task cyc_n(input int n);
        repeat (n) @(negedge clock_in);
    endtask : cyc_n

    task wait_sig(input sig_t s);
        int k;
        k = 0;
        while (sig !== s && k < 40) begin
            cyc_n(1);
            k++;
        end
        chk("signature", 8'(sig), 8'(s));
    endtask : wait_sig

    // pins {a,b,c,limit} to expected mode code
    function automatic int exp_mode(input int p);
        int abc;
        abc = p >> 1;
        if (abc == 0) return 0;
        if (abc == 1 || abc == 3) return 1;
        if (abc == 2 || abc == 6) return 2;
        if (abc == 4) return 3;
        if (abc == 5) return 4;
        return p[0] ? 6 : 5;
    endfunction : exp_mode

    task check_state(input int p);
        int m;
        m = exp_mode(p);
        chk("mode", 8'(mode), 8'(m));
        chk("data", 8'(data_on), 8'((m == 2 || m >= 5) && enable_in));
        chk("discharge", 8'(disch), 8'(m == 0));
        chk("power", 8'(power_on), 8'(m != 0));
        if (m != 0) chk("limit", 8'(hl), 8'(m == 1 || p[0]));
        chk("signature", 8'(sig), 8'((m == 1 || m == 4) ? 1 : (m == 3 ? 4 : 0)));
        chk("fault", 8'(fault_n), 8'(!(ot || icl)));
    endtask : check_state

    initial begin
        int k;
        logic d;
        resetn_in = 0;
        enable_in = 1;
        por_in = 1;
        pins = 4'hD;
        {ot, icl, attach, draw} = 4'h0;
        cyc_n(8);
        resetn_in = 1;
        cyc_n(10);
        chk("por discharge", 8'(disch), 8'h1);
        chk("por signature", 8'(sig), 8'h0);
        por_in = 0;
        cyc_n(8);
        check_state(13);
        k = $random(seed) & 15;
        for (int i = 0; i < 16; i++) begin
            pins = 4'(i ^ k);
            icl = 1'($random(seed));
            cyc_n(24);
            check_state(i ^ k);
        end
        icl = 0;
        pins = 4'hF;
        cyc_n(24);
        pins = 4'hE;
        d = 0;
        for (int i = 0; i < 8; i++) begin
            cyc_n(1);
            d = d | disch;
        end
        chk("swap discharge", 8'(d), 8'h0);
        check_state(14);
        enable_in = 0;
        cyc_n(5);
        chk("enable data", 8'(data_on), 8'h0);
        chk("enable power", 8'(power_on), 8'h0);
        enable_in = 1;
        cyc_n(24);
        check_state(14);
        pins = 4'h2;
        cyc_n(24);
        check_state(2);
        cyc_n(20);
        chk("divider hold", 8'(sig), 8'(SIG_FIRST_DIVIDER));
        attach = 1;
        k = 0;
        while (disch !== 1'b1 && k < 10) begin
            cyc_n(1);
            k++;
        end
        chk("attach discharge", 8'(disch), 8'h1);
        wait_sig(SIG_V1P2);
        chk("1.2V power", 8'(power_on), 8'h1);
        k = 0;
        while (sig === SIG_V1P2 && k < 40) begin
            cyc_n(1);
            k++;
        end
        chk("1.2V length", 8'(k >= 14 && k <= 18), 8'h1);
        chk("shorted", 8'(sig), 8'(SIG_SHORTED));
        cyc_n(20);
        chk("shorted hold", 8'(sig), 8'(SIG_SHORTED));
        attach = 0;
        wait_sig(SIG_FIRST_DIVIDER);
        draw = 1;
        wait_sig(SIG_SECOND_DIVIDER);
        cyc_n(20);
        chk("trial keep", 8'(sig), 8'(SIG_SECOND_DIVIDER));
        por_in = 1;
        cyc_n(6);
        chk("por again", 8'(disch), 8'h1);
        draw = 0;
        por_in = 0;
        cyc_n(24);
        check_state(2);
        draw = 1;
        wait_sig(SIG_SECOND_DIVIDER);
        draw = 0;
        cyc_n(24);
        chk("trial drop", 8'(sig), 8'(SIG_FIRST_DIVIDER));
        ot = 1;
        cyc_n(5);
        chk("over temp", 8'(fault_n), 8'h0);
        results;
    end
endmodule : usb_charge_port_mode_control_tb_top

`default_nettype wire
